// ==== lcd_pkg.sv ====
// package: register map, field positions, reset values, timing counts, engine states
package lcd_pkg;
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_START = 4'h1;
  localparam logic [3:0] ADDR_WIDTH = 4'h2;
  localparam logic [3:0] ADDR_HEIGHT = 4'h3;
  localparam logic [3:0] ADDR_PAGE = 4'h4;
  localparam logic [3:0] ADDR_ALT = 4'h5;
  localparam logic [3:0] ADDR_CONTRAST = 4'h6;
  localparam logic [3:0] ADDR_PORTL = 4'h7;
  localparam logic [3:0] ADDR_STATUS = 4'h8;

  localparam int CTRL_GRAY = 2;
  localparam int CTRL_THIRD = 3;
  localparam int CTRL_BUS4 = 4;
  localparam int CTRL_INVERT = 5;
  localparam int CTRL_DISPOFF = 6;
  localparam int CTRL_POWER = 7;

  localparam logic [7:0] RST_CTRL = 8'h80;
  localparam logic [13:0] RST_START = 14'h0000;
  localparam logic [10:0] RST_WIDTH = 11'h0A0;
  localparam logic [9:0] RST_HEIGHT = 10'h050;
  localparam logic [8:0] RST_PAGE = 9'h014;
  localparam logic [4:0] RST_ALT = 5'h00;
  localparam logic [5:0] RST_CONTRAST = 6'h00;
  localparam logic [7:0] RST_PORTL = 8'h00;

  localparam int CLK_NS = 10;
  localparam int SHIFT_HALF_NS = 20;
  localparam int LINE_PULSE_NS = 100;
  localparam logic [2:0] SHIFT_HALF_CYC = 3'((SHIFT_HALF_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] LINE_PULSE_CYC = 4'((LINE_PULSE_NS + CLK_NS - 1) / CLK_NS);

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_FETCH = 5'b00010,
    ST_WAIT = 5'b00100,
    ST_SHIFT = 5'b01000,
    ST_LINE = 5'b10000
  } state_t;
endpackage

// ==== contrast_if.sv ====
// interface: contrast setting and blank waveform between engine and pwm generator
`timescale 1ns/1ps
`default_nettype none
interface contrast_if;
  logic [5:0] level;
  logic force_low;
  logic blank;
  modport ctrl (output level, output force_low, input blank);
  modport gen (input level, input force_low, output blank);
endinterface
`default_nettype wire

// ==== contrast_pwm.sv ====
// module: pwm generator for the panel blank / contrast output
`timescale 1ns/1ps
`default_nettype none
module contrast_pwm (
  input wire logic clk,
  input wire logic rst,
  contrast_if.gen pw
);
  logic [5:0] pwm_cnt;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pwm_cnt <= 6'h00;
    end else begin
      pwm_cnt <= pwm_cnt + 6'h01;
    end
  end

  // high share shrinks as level grows; level zero stays high
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pw.blank <= 1'b1;
    end else if (pw.force_low) begin
      pw.blank <= 1'b0; // [RULE_14]
    end else begin
      pw.blank <= (pwm_cnt >= pw.level); // [RULE_13] [RULE_15]
    end
  end
endmodule
`default_nettype wire

// ==== mono_stn_lcd_controller.sv ====
// module: monochrome stn panel refresh engine with register port and port-l mux
//
// Summary of operation
// RULE_01 - gray bit clear: one bit per pixel
// RULE_02 - second gray bit picks half or third
// RULE_03 - bw 0 white; gray 00 white, 11 dark
// RULE_04 - byte msb is leftmost pixel
// RULE_05 - bus bit selects serial or 4-bit data
// RULE_06 - power off: port pins show port data
// RULE_07 - frame marker from last line to next
// RULE_08 - one line pulse per display row
// RULE_09 - alternation per frame or 1..31 lines
// RULE_10 - data stable around shift clock falling edge
// RULE_11 - invert bit complements every pixel bit
// RULE_12 - supply-off output is inverse of power
// RULE_13 - blank pwm duty follows contrast field
// RULE_14 - display-off bit forces blank low
// RULE_15 - zero contrast keeps blank steady high
// RULE_16 - programmable size and virtual page width
// RULE_17 - fetches use own memory read port
// RULE_18 - powered panel refreshes continuously
// RULE_19 - row address steps by page width
// RULE_20 - shift clock idle during line pulse
// RULE_21 - no shading beyond four levels
//
// The strobed register port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module mono_stn_lcd_controller (
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  output logic [13:0] mem_addr,
  output logic mem_rd,
  input wire logic [7:0] mem_rdata,
  output logic [7:0] port_l_pins,
  output logic panel_supply_off_out,
  output logic blank_out
);
  logic [7:0] display_control_reg;
  logic [13:0] start_addr;
  logic [10:0] screen_width;
  logic [9:0] screen_height;
  logic [8:0] page_width;
  logic [4:0] alt_lines;
  logic [5:0] contrast_level_field;
  logic [7:0] port_l_out_data;

  logic panel_power_bit;
  logic bus_width_bit;
  logic data_invert_bit;
  logic display_off_bit;
  logic [1:0] gray_mode_bits;

  lcd_pkg::state_t state;
  logic [13:0] row_addr;
  logic [13:0] byte_addr;
  logic [10:0] pix_left;
  logic [9:0] row_cnt;
  logic [7:0] pix_byte;
  logic [3:0] pix_idx;
  logic [2:0] div_cnt;
  logic [3:0] lp_cnt;
  logic [4:0] alt_cnt;
  logic [1:0] frame_mod3;
  logic frame_par;
  logic frame_marker;
  logic line_pulse;
  logic polarity_alternation;
  logic shift_clock_out;
  logic [3:0] pixel_data_bus;

  logic [10:0] step;
  logic [3:0] per_byte;
  logic [3:0] next_data;
  logic [15:0] next_rdata;
  logic [13:0] next_row_addr;
  logic last_row;

  contrast_if pwm_bus ();

  assign panel_power_bit = display_control_reg[lcd_pkg::CTRL_POWER];
  assign bus_width_bit = display_control_reg[lcd_pkg::CTRL_BUS4];
  assign data_invert_bit = display_control_reg[lcd_pkg::CTRL_INVERT];
  assign display_off_bit = display_control_reg[lcd_pkg::CTRL_DISPOFF];
  assign gray_mode_bits = {display_control_reg[lcd_pkg::CTRL_THIRD], display_control_reg[lcd_pkg::CTRL_GRAY]};

  assign step = bus_width_bit ? 11'h004 : 11'h001; // [RULE_05]
  assign per_byte = gray_mode_bits[0] ? 4'h4 : 4'h8; // [RULE_01]
  assign next_row_addr = row_addr + {5'h00, page_width}; // [RULE_19]
  assign last_row = (row_cnt == screen_height - 10'h001);

  assign pwm_bus.level = contrast_level_field;
  assign pwm_bus.force_low = display_off_bit;

  contrast_pwm u_pwm (
    .clk(clk),
    .rst(rst),
    .pw(pwm_bus.gen)
  );

  // pixel i of a byte, msb side first
  function automatic logic [1:0] pixel_at(input logic [7:0] b, input logic [3:0] i, input logic g);
    logic [7:0] s;
    begin
      s = g ? (b << {i[1:0], 1'b0}) : (b << i[2:0]); // [RULE_04]
      pixel_at = g ? s[7:6] : {1'b0, s[7]}; // [RULE_01]
    end
  endfunction

  // frame-rate shading for the two middle gray levels only
  function automatic logic render(input logic [1:0] lvl, input logic g, input logic third,
                                  input logic [1:0] m3, input logic par);
    begin
      if (!g) begin
        render = lvl[0]; // [RULE_03]
      end else begin
        case (lvl) // [RULE_03] [RULE_21]
          2'b00: render = 1'b0;
          2'b01: render = third ? (m3 == 2'h0) : par; // [RULE_02]
          2'b10: render = (m3 != 2'h0);
          default: render = 1'b1;
        endcase
      end
    end
  endfunction

  always_comb begin
    logic [3:0] p;
    logic b;
    p = 4'h0;
    b = 1'b0;
    next_data = 4'h0;
    for (int k = 0; k < 4; k++) begin
      p = pix_idx + 4'(k);
      b = render(pixel_at(pix_byte, p, gray_mode_bits[0]), gray_mode_bits[0], gray_mode_bits[1],
                 frame_mod3, frame_par) ^ data_invert_bit; // [RULE_11]
      if (bus_width_bit) begin
        next_data[3 - k] = b; // [RULE_05]
      end else if (k == 0) begin
        next_data[0] = b; // [RULE_05]
      end
    end
  end

  // register writes
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      display_control_reg <= lcd_pkg::RST_CTRL; // [RULE_12]
      start_addr <= lcd_pkg::RST_START;
      screen_width <= lcd_pkg::RST_WIDTH;
      screen_height <= lcd_pkg::RST_HEIGHT;
      page_width <= lcd_pkg::RST_PAGE;
      alt_lines <= lcd_pkg::RST_ALT;
      contrast_level_field <= lcd_pkg::RST_CONTRAST;
      port_l_out_data <= lcd_pkg::RST_PORTL;
    end else if (reg_wr) begin
      case (reg_addr)
        lcd_pkg::ADDR_CTRL: display_control_reg <= {reg_wdata[7:2], 2'b00};
        lcd_pkg::ADDR_START: start_addr <= reg_wdata[13:0];
        lcd_pkg::ADDR_WIDTH: screen_width <= reg_wdata[10:0]; // [RULE_16]
        lcd_pkg::ADDR_HEIGHT: screen_height <= reg_wdata[9:0]; // [RULE_16]
        lcd_pkg::ADDR_PAGE: page_width <= reg_wdata[8:0]; // [RULE_16]
        lcd_pkg::ADDR_ALT: alt_lines <= reg_wdata[4:0];
        lcd_pkg::ADDR_CONTRAST: contrast_level_field <= reg_wdata[5:0];
        lcd_pkg::ADDR_PORTL: port_l_out_data <= reg_wdata[7:0];
        default: begin
        end
      endcase
    end
  end

  // read mux, unmapped reads give zero
  always_comb begin
    case (reg_addr)
      lcd_pkg::ADDR_CTRL: next_rdata = {8'h00, display_control_reg};
      lcd_pkg::ADDR_START: next_rdata = {2'h0, start_addr};
      lcd_pkg::ADDR_WIDTH: next_rdata = {5'h00, screen_width};
      lcd_pkg::ADDR_HEIGHT: next_rdata = {6'h00, screen_height};
      lcd_pkg::ADDR_PAGE: next_rdata = {7'h00, page_width};
      lcd_pkg::ADDR_ALT: next_rdata = {11'h000, alt_lines};
      lcd_pkg::ADDR_CONTRAST: next_rdata = {10'h000, contrast_level_field};
      lcd_pkg::ADDR_PORTL: next_rdata = {8'h00, port_l_out_data};
      lcd_pkg::ADDR_STATUS: next_rdata = {4'h0, polarity_alternation, frame_marker, row_cnt};
      default: next_rdata = 16'h0000;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 16'h0000;
    end else begin
      reg_rdata <= reg_rd ? next_rdata : 16'h0000;
    end
  end

  // refresh engine: fetch byte, shift pixels, line pulse, repeat
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= lcd_pkg::ST_IDLE;
      row_addr <= 14'h0000;
      byte_addr <= 14'h0000;
      pix_left <= 11'h000;
      row_cnt <= 10'h000;
      pix_byte <= 8'h00;
      pix_idx <= 4'h0;
      div_cnt <= 3'h0;
      lp_cnt <= 4'h0;
      alt_cnt <= 5'h00;
      frame_mod3 <= 2'h0;
      frame_par <= 1'b0;
      frame_marker <= 1'b0;
      line_pulse <= 1'b0;
      polarity_alternation <= 1'b0;
      shift_clock_out <= 1'b0;
      pixel_data_bus <= 4'h0;
      mem_addr <= 14'h0000;
      mem_rd <= 1'b0;
    end else if (!panel_power_bit) begin
      state <= lcd_pkg::ST_IDLE;
      frame_marker <= 1'b0;
      line_pulse <= 1'b0;
      shift_clock_out <= 1'b0;
      mem_rd <= 1'b0;
    end else begin
      case (state)
        lcd_pkg::ST_IDLE: begin
          row_addr <= start_addr;
          byte_addr <= start_addr;
          row_cnt <= 10'h000;
          pix_left <= screen_width;
          lp_cnt <= 4'h0;
          state <= (screen_width == 11'h000) ? lcd_pkg::ST_LINE : lcd_pkg::ST_FETCH;
        end
        lcd_pkg::ST_FETCH: begin
          mem_addr <= byte_addr; // [RULE_17]
          mem_rd <= 1'b1; // [RULE_17]
          state <= lcd_pkg::ST_WAIT;
        end
        lcd_pkg::ST_WAIT: begin
          mem_rd <= 1'b0;
          if (!mem_rd) begin
            pix_byte <= mem_rdata;
            pix_idx <= 4'h0;
            byte_addr <= byte_addr + 14'h0001;
            div_cnt <= 3'h0;
            state <= lcd_pkg::ST_SHIFT;
          end
        end
        lcd_pkg::ST_SHIFT: begin
          div_cnt <= div_cnt + 3'h1;
          if (div_cnt == 3'h0) begin
            pixel_data_bus <= next_data; // [RULE_10]
            shift_clock_out <= 1'b1; // [RULE_20]
          end
          if (div_cnt == lcd_pkg::SHIFT_HALF_CYC) begin
            shift_clock_out <= 1'b0; // [RULE_10]
          end
          if (div_cnt == (lcd_pkg::SHIFT_HALF_CYC << 1) - 3'h1) begin
            div_cnt <= 3'h0;
            pix_idx <= pix_idx + step[3:0];
            pix_left <= (pix_left > step) ? pix_left - step : 11'h000;
            if (pix_left <= step) begin
              lp_cnt <= 4'h0;
              state <= lcd_pkg::ST_LINE;
            end else if (pix_idx + step[3:0] >= per_byte) begin
              state <= lcd_pkg::ST_FETCH;
            end
          end
        end
        lcd_pkg::ST_LINE: begin
          shift_clock_out <= 1'b0; // [RULE_20]
          lp_cnt <= lp_cnt + 4'h1;
          line_pulse <= 1'b1; // [RULE_08]
          if (lp_cnt == lcd_pkg::LINE_PULSE_CYC - 4'h1) begin
            line_pulse <= 1'b0;
            lp_cnt <= 4'h0;
            pix_left <= screen_width;
            if (alt_lines != 5'h00) begin
              if (alt_cnt + 5'h01 >= alt_lines) begin
                alt_cnt <= 5'h00;
                polarity_alternation <= ~polarity_alternation; // [RULE_09]
              end else begin
                alt_cnt <= alt_cnt + 5'h01;
              end
            end
            if (last_row) begin
              frame_marker <= 1'b1; // [RULE_07]
              row_cnt <= 10'h000;
              row_addr <= start_addr; // [RULE_19]
              byte_addr <= start_addr;
              frame_par <= ~frame_par;
              frame_mod3 <= (frame_mod3 == 2'h2) ? 2'h0 : frame_mod3 + 2'h1;
              if (alt_lines == 5'h00) begin
                polarity_alternation <= ~polarity_alternation; // [RULE_09]
              end
            end else begin
              frame_marker <= 1'b0; // [RULE_07]
              row_cnt <= row_cnt + 10'h001;
              row_addr <= next_row_addr; // [RULE_19]
              byte_addr <= next_row_addr;
            end
            state <= (screen_width == 11'h000) ? lcd_pkg::ST_LINE : lcd_pkg::ST_FETCH; // [RULE_18]
          end
        end
        default: begin
          state <= lcd_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // port-l pin mux and dedicated outputs
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      port_l_pins <= 8'h00;
      panel_supply_off_out <= 1'b0;
      blank_out <= 1'b1;
    end else begin
      panel_supply_off_out <= ~panel_power_bit; // [RULE_12]
      blank_out <= pwm_bus.blank; // [RULE_13] [RULE_14]
      if (!panel_power_bit) begin
        port_l_pins <= port_l_out_data; // [RULE_06]
      end else if (bus_width_bit) begin
        port_l_pins <= {frame_marker, line_pulse, polarity_alternation, shift_clock_out, pixel_data_bus};
      end else begin
        port_l_pins <= {frame_marker, line_pulse, polarity_alternation, shift_clock_out,
                        port_l_out_data[3:1], pixel_data_bus[0]}; // [RULE_05]
      end
    end
  end
endmodule
`default_nettype wire

// ==== lcd_properties.sv ====
// checker: port-level properties of the lcd refresh engine
`timescale 1ns/1ps
`default_nettype none
module lcd_properties (
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic [13:0] mem_addr,
  input wire logic mem_rd,
  input wire logic [7:0] mem_rdata,
  input wire logic [7:0] port_l_pins,
  input wire logic panel_supply_off_out,
  input wire logic blank_out
);
  logic [7:0] ctrl_sh;
  logic [7:0] port_sh;
  logic [5:0] con_sh;
  logic on;
  assign on = !panel_supply_off_out;
  // shadow of the written control values
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_sh <= lcd_pkg::RST_CTRL;
      port_sh <= lcd_pkg::RST_PORTL;
      con_sh <= lcd_pkg::RST_CONTRAST;
    end else if (reg_wr) begin
      if (reg_addr == lcd_pkg::ADDR_CTRL) ctrl_sh <= reg_wdata[7:0];
      if (reg_addr == lcd_pkg::ADDR_PORTL) port_sh <= reg_wdata[7:0];
      if (reg_addr == lcd_pkg::ADDR_CONTRAST) con_sh <= reg_wdata[5:0];
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000) else $error("read data not zero");
  a_unmapped_read: assert property (reg_rd && reg_addr > lcd_pkg::ADDR_STATUS |=> reg_rdata == 16'h0000)
    else $error("unmapped read not zero");
  a_fetch_pulse: assert property (mem_rd |=> !mem_rd [*4]) else $error("fetch pulse too long");
  a_line_no_shift: assert property (on && port_l_pins[6] |-> !port_l_pins[4]) else $error("shift in line");
  a_shift_shape: assert property (on && $rose(port_l_pins[4]) |=> port_l_pins[4] ##1 !port_l_pins[4])
    else $error("shift clock shape");
  a_line_width: assert property (on && $rose(port_l_pins[6]) |=> port_l_pins[6] [*8] ##1 !port_l_pins[6])
    else $error("line pulse width");
  a_supply_follow: assert property ($stable(ctrl_sh[7]) [*3] |-> panel_supply_off_out == !ctrl_sh[7])
    else $error("supply off level");
  a_port_off: assert property ((!ctrl_sh[7] && $stable(port_sh)) [*3] |-> port_l_pins == port_sh)
    else $error("port pins not port data");
  a_blank_forced: assert property (ctrl_sh[6] [*4] |-> !blank_out) else $error("blank not forced");
  a_blank_steady: assert property ((con_sh == 6'h00 && !ctrl_sh[6]) [*4] |-> blank_out)
    else $error("blank not steady");
endmodule
`default_nettype wire

// ==== ram_model.sv ====
// model: display ram answering a fetch one cycle after the read pulse
`timescale 1ns/1ps
`default_nettype none
module ram_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic mem_rd,
  input wire logic [13:0] mem_addr,
  output logic [7:0] mem_rdata
);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mem_rdata <= 8'h55;
    end else if (mem_rd) begin
      mem_rdata <= mem_addr[7:0] ^ 8'h3C;
    end else begin
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule
`default_nettype wire

// ==== tb_top.sv ====
// testbench: registers, pixel stream, line and frame timing, blank
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  typedef struct packed {logic [3:0] a; logic [15:0] d;} row_t;
  logic clk, rst, reg_wr, reg_rd, mem_rd, supply_off, blank_out, a0;
  logic [3:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata;
  logic [13:0] mem_addr;
  logic [7:0] mem_rdata, pins, prev, v;
  int fails, cmp_count, cyc, n;
  row_t rows [9] = '{{4'h1, 16'h0000}, {4'h2, 16'h00A0}, {4'h3, 16'h0050}, {4'h4, 16'h0014},
    {4'h5, 16'h0000}, {4'h6, 16'h0000}, {4'h7, 16'h0000}, {4'h9, 16'h0000}, {4'hF, 16'h0000}};
  mono_stn_lcd_controller dut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mem_addr(mem_addr), .mem_rd(mem_rd),
    .mem_rdata(mem_rdata), .port_l_pins(pins), .panel_supply_off_out(supply_off), .blank_out(blank_out));
  ram_model ram (.clk(clk), .rst(rst), .mem_rd(mem_rd), .mem_addr(mem_addr), .mem_rdata(mem_rdata));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) prev <= pins;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      conclude();
    end
  end
  task automatic conclude;
    $display("checks %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk("reg_rdata", e, reg_rdata);
  endtask
  // wait for pin b to change into level lvl
  task automatic await(input int b, input logic lvl);
    int k;
    k = 0;
    do begin
      @(posedge clk);
      #1 k++;
      if (pins[6] === 1'b1 && prev[6] === 1'b0) n++;
    end while (!(pins[b] === lvl && prev[b] === !lvl) && k < 4000);
    if (k >= 4000) chk("wait", 16'h0001, 16'h0000);
  endtask
  // collect pixels at falling shift clock
  task automatic grab(input int cnt, input logic wide);
    v = 8'h00;
    repeat (cnt) begin
      await(4, 1'b0);
      v = wide ? {v[3:0], pins[3:0]} : {v[6:0], pins[0]};
    end
  endtask
  task automatic fetch_at(input logic [13:0] e);
    int k;
    k = 0;
    do begin
      @(posedge clk);
      #1 k++;
    end while (mem_rd !== 1'b1 && k < 4000);
    if (k >= 4000) chk("fetch wait", 16'h0001, 16'h0000);
    chk("mem_addr", {2'h0, e}, {2'h0, mem_addr});
  endtask
  // dark counts of a light and a mid gray pixel over six frames
  task automatic shade(input logic [15:0] e_lite);
    int lite;
    int mid;
    lite = 0;
    mid = 0;
    repeat (6) begin
      await(7, 1'b1);
      grab(2, 1'b0);
      lite += int'(v[1]);
      mid += int'(v[0]);
    end
    chk("light gray frames", e_lite, 16'(lite));
    chk("mid gray frames", 16'h0004, 16'(mid));
  endtask
  initial begin
    rst = 1'b1;
    {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rd(4'h0, 16'h0080);
    wr(4'h0, 16'h0000);
    foreach (rows[i]) rd(rows[i].a, rows[i].d);
    wr(4'h7, 16'h00A5);
    repeat (4) @(posedge clk);
    chk("port pins off", 16'h00A5, {8'h00, pins});
    chk("supply off", 16'h0001, {15'h0000, supply_off});
    $display("test reset and power off done");
    wr(4'h1, 16'h0010);
    wr(4'h2, 16'h0008);
    wr(4'h3, 16'h0002);
    wr(4'h4, 16'h0004);
    wr(4'h0, 16'h0080);
    await(7, 1'b1);
    grab(8, 1'b0);
    chk("bw row", 16'h002C, {8'h00, v});
    chk("spare pins", 16'h0002, {13'h0000, pins[3:1]});
    fetch_at(14'h0014);
    fetch_at(14'h0010);
    await(7, 1'b1);
    n = 0;
    a0 = pins[5];
    await(7, 1'b1);
    chk("lines per frame", 16'h0002, 16'(n));
    chk("alternation frame", {15'h0000, !a0}, {15'h0000, pins[5]});
    wr(4'h5, 16'h0001);
    await(6, 1'b1);
    a0 = pins[5];
    await(6, 1'b1);
    chk("alternation line", {15'h0000, !a0}, {15'h0000, pins[5]});
    $display("test bw stream done");
    wr(4'h0, 16'h00A0);
    await(7, 1'b1);
    grab(8, 1'b0);
    chk("inverted row", 16'h00D3, {8'h00, v});
    wr(4'h0, 16'h0090);
    await(7, 1'b1);
    grab(2, 1'b1);
    chk("4-bit row", 16'h002C, {8'h00, v});
    wr(4'h1, 16'h00CC);
    wr(4'h2, 16'h0004);
    wr(4'h0, 16'h0084);
    await(7, 1'b1);
    await(7, 1'b1);
    grab(4, 1'b0);
    chk("gray row", 16'h000C, {8'h00, v});
    wr(4'h1, 16'h005C);
    shade(16'h0003);
    wr(4'h0, 16'h008C);
    shade(16'h0002);
    $display("test modes done");
    wr(4'h6, 16'h0020);
    repeat (8) @(posedge clk);
    n = 0;
    repeat (64) begin
      @(posedge clk);
      #1 n += int'(blank_out === 1'b1);
    end
    chk("blank duty", 16'h0020, 16'(n));
    wr(4'h0, 16'h00C0);
    repeat (6) @(posedge clk);
    chk("blank off", 16'h0000, {15'h0000, blank_out});
    await(6, 1'b0);
    wr(4'h0, 16'h0000);
    repeat (4) @(posedge clk);
    chk("port pins off", 16'h00A5, {8'h00, pins});
    $display("test blank and power off done");
    conclude();
  end
endmodule
bind mono_stn_lcd_controller lcd_properties chk_i (.clk(clk), .rst(rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mem_addr(mem_addr),
  .mem_rd(mem_rd), .mem_rdata(mem_rdata), .port_l_pins(port_l_pins),
  .panel_supply_off_out(panel_supply_off_out), .blank_out(blank_out));
`default_nettype wire
